// [hw/ctrl_regs_pkg.sv]
// Purpose: constants and carrier types for the cpu/otg control bank
// Assumes: 32-bit apb, one clock, synchronous active-low reset
// Notes: every register except event status keeps a 16-bit value plus a write mask on top
package ctrl_regs_pkg;

    // ***************************************************************
    // register byte offsets
    // ***************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CPU_CORE_CTRL_OFS = 12'h2F8;
    localparam logic [11:0] CPU_FILTER_START_LOW_OFS = 12'h2FC;
    localparam logic [11:0] CPU_FILTER_END_LOW_OFS = 12'h300;
    localparam logic [11:0] CPU_FILTER_HIGH_AND_FIQ_OFS = 12'h304;
    localparam logic [11:0] CPU_MARGIN_AND_EVENTS_OFS = 12'h308;
    localparam logic [11:0] CPU_EVENT_STATUS_OFS = 12'h318;
    localparam logic [11:0] OTG_PHY_POWER_CONTROL_OFS = 12'h320;
    localparam logic [11:0] OTG_PHY_TRANSMIT_TRIM_OFS = 12'h324;

    // ***************************************************************
    // reset values and implemented-bit masks
    // ***************************************************************
    localparam logic [15:0] CORE_CTRL_RST = 16'h0220;
    localparam logic [15:0] CORE_CTRL_IMPL = 16'h03FF;
    localparam logic [15:0] START_LOW_RST = 16'h0FF0;
    localparam logic [15:0] END_LOW_RST = 16'h0FFF;
    localparam logic [15:0] FULL_IMPL = 16'hFFFF;
    localparam logic [15:0] HIGH_FIQ_RST = 16'h0000;
    localparam logic [15:0] HIGH_FIQ_IMPL = 16'h0FFF;
    localparam logic [15:0] MARGIN_RST = 16'h2400;
    localparam logic [15:0] MARGIN_IMPL = 16'hFF0F;
    localparam logic [15:0] OTG_PWR_RST = 16'h0089;
    localparam logic [15:0] OTG_PWR_IMPL = 16'hF3FF;
    localparam logic [15:0] OTG_TRIM_RST = 16'h7330;
    localparam logic [15:0] OTG_TRIM_IMPL = 16'hFFF0;
    localparam logic [15:0] STATUS_SW_IMPL = 16'h4000;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int unsigned MASK_LSB = 16;
    localparam int unsigned EVT_RISE_BIT = 14;
    localparam int unsigned PMU_LSB = 2;
    localparam int unsigned LINE_PEND_BIT = 15;
    localparam int unsigned LINE_EN_BIT = 14;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic trace_port_ctl;
        logic [3:0] debug_instance_id;
        logic l2_reset_hold_off;
        logic [3:0] per_core_l1_reset_hold_off;
        logic [19:0] filter_start;
        logic [19:0] filter_end;
        logic [3:0] core_nonmaskable_fast_irq_cfg;
        logic [2:0] l2_ram_margin;
        logic [2:0] core_ram_margin;
        logic event_out_clear;
        logic event_in_drive;
        logic [3:0] core_exception_state_init;
    } cpu_cfg_t;

    typedef struct packed {
        logic line_irq_enable;
        logic analog_power_down;
        logic port_reset;
        logic [1:0] scale_down_mode;
        logic [2:0] vbus_valid_trim;
        logic block_power_down;
        logic [2:0] disconnect_trim;
        logic common_down_in_suspend;
        logic [1:0] rise_fall_trim;
        logic [1:0] crossover_trim;
        logic [3:0] hs_dc_trim;
        logic [3:0] fsls_impedance_trim;
    } otg_cfg_t;

    typedef struct packed {
        logic [3:0] pmu_priv1_event;
        logic [3:0] pmu_priv2_event;
        logic [3:0] pmu_secure_event;
    } pmu_evt_t;

endpackage

// [hw/cpu_otg_ctrl_regs.sv]
// Purpose: apb bank of cpu cluster and otg phy static controls
// Assumes: event and pmu inputs are asynchronous to clk_i
// Notes: slave answers one cycle into the access phase

// Functional notes
// - upper half bit n+16 enables lower bit n
// - trace ctl, debug id, l2 hold-off fields
// - per-core l1 reset hold-off, bits 3:0
// - filter start = con3[3:0] : con1
// - filter end = con3[7:4] : con2
// - per-core fast irq config 11:8
// - l2 and core ram margins reset 1
// - event out clear and event in drive
// - per-core exception state init 3:0
// - event out rising edge recorded bit 14
// - pmu event fields per core in status
// - line-state pending 15, enable 14
// - bit 13 powers down phy analog
// - bit 12 holds phy port fsms reset
// - scale-down mode bits 9:8
// - vbus valid trim 7:5 reset 4
// - bit 4 powers down otg block
// - disconnect trim 3:1 reset 4
// - bit 0 common blocks down in suspend
// - rise/fall, dc level, impedance trims
// - crossover trim 13:12 reset 3
module cpu_otg_ctrl_regs
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ctrl_regs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // cluster side
    input wire logic event_out_i,
    input wire ctrl_regs_pkg::pmu_evt_t pmu_evt_i,
    output ctrl_regs_pkg::cpu_cfg_t cpu_cfg_o,
    // otg phy side
    input wire logic [1:0] line_state_i,
    output ctrl_regs_pkg::otg_cfg_t otg_cfg_o,
    output logic otg_line_irq_o
);

    // ***************************************************************
    // storage
    // ***************************************************************
    logic [15:0] core_ctrl_reg;
    logic [15:0] start_low_reg;
    logic [15:0] end_low_reg;
    logic [15:0] high_fiq_reg;
    logic [15:0] margin_reg;
    logic [15:0] otg_pwr_reg;
    logic [15:0] otg_trim_reg;
    logic evt_rise_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic irq_reg;

    // two-flop synchronisers plus one history flop for edges
    logic evt_s1_reg;
    logic evt_s2_reg;
    logic evt_prev_reg;
    ctrl_regs_pkg::pmu_evt_t pmu_s1_reg;
    ctrl_regs_pkg::pmu_evt_t pmu_s2_reg;
    logic [1:0] line_s1_reg;
    logic [1:0] line_s2_reg;
    logic [1:0] line_prev_reg;

    // ***************************************************************
    // bus decode
    // ***************************************************************
    logic access;
    logic wr;
    logic hit;
    logic [15:0] wd;
    logic [15:0] we;
    logic [15:0] rd_val;

    assign access = psel_i & penable_i & pready_reg;
    assign wr = access & pwrite_i;
    assign wd = pwdata_i[15:0];
    assign we = pwdata_i[31:ctrl_regs_pkg::MASK_LSB];

    // masked merge; bits outside impl never change
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] impl
    );
        merge = (old & ~(we & impl)) | (wd & we & impl);
    endfunction

    function automatic logic sel(input logic [11:0] ofs);
        sel = wr & (paddr_i == ofs);
    endfunction

    // ***************************************************************
    // cpu control registers
    // ***************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            core_ctrl_reg <= ctrl_regs_pkg::CORE_CTRL_RST;
        end
        else if (sel(ctrl_regs_pkg::CPU_CORE_CTRL_OFS))
        begin
            core_ctrl_reg <= merge(core_ctrl_reg,
                ctrl_regs_pkg::CORE_CTRL_IMPL);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            start_low_reg <= ctrl_regs_pkg::START_LOW_RST;
        end
        else if (sel(ctrl_regs_pkg::CPU_FILTER_START_LOW_OFS))
        begin
            start_low_reg <= merge(start_low_reg,
                ctrl_regs_pkg::FULL_IMPL);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            end_low_reg <= ctrl_regs_pkg::END_LOW_RST;
        end
        else if (sel(ctrl_regs_pkg::CPU_FILTER_END_LOW_OFS))
        begin
            end_low_reg <= merge(end_low_reg,
                ctrl_regs_pkg::FULL_IMPL);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            high_fiq_reg <= ctrl_regs_pkg::HIGH_FIQ_RST;
        end
        else if (sel(ctrl_regs_pkg::CPU_FILTER_HIGH_AND_FIQ_OFS))
        begin
            high_fiq_reg <= merge(high_fiq_reg,
                ctrl_regs_pkg::HIGH_FIQ_IMPL);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            margin_reg <= ctrl_regs_pkg::MARGIN_RST;
        end
        else if (sel(ctrl_regs_pkg::CPU_MARGIN_AND_EVENTS_OFS))
        begin
            margin_reg <= merge(margin_reg,
                ctrl_regs_pkg::MARGIN_IMPL);
        end
    end

    // ***************************************************************
    // otg phy control registers
    // ***************************************************************
    logic line_change;
    logic [15:0] otg_pwr_next;

    assign line_change = line_s2_reg != line_prev_reg;

    always_comb
    begin
        otg_pwr_next = otg_pwr_reg;
        if (sel(ctrl_regs_pkg::OTG_PHY_POWER_CONTROL_OFS))
        begin
            otg_pwr_next = merge(otg_pwr_reg,
                ctrl_regs_pkg::OTG_PWR_IMPL);
        end
        // a line change in the clearing cycle still sets pending
        if (line_change)
        begin
            otg_pwr_next[ctrl_regs_pkg::LINE_PEND_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            otg_pwr_reg <= ctrl_regs_pkg::OTG_PWR_RST;
        end
        else
        begin
            otg_pwr_reg <= otg_pwr_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            otg_trim_reg <= ctrl_regs_pkg::OTG_TRIM_RST;
        end
        else if (sel(ctrl_regs_pkg::OTG_PHY_TRANSMIT_TRIM_OFS))
        begin
            otg_trim_reg <= merge(otg_trim_reg,
                ctrl_regs_pkg::OTG_TRIM_IMPL);
        end
    end

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            evt_s1_reg <= 1'b0;
            evt_s2_reg <= 1'b0;
            evt_prev_reg <= 1'b0;
            pmu_s1_reg <= '0;
            pmu_s2_reg <= '0;
            line_s1_reg <= 2'h0;
            line_s2_reg <= 2'h0;
            line_prev_reg <= 2'h0;
        end
        else
        begin
            evt_s1_reg <= event_out_i;
            evt_s2_reg <= evt_s1_reg;
            evt_prev_reg <= evt_s2_reg;
            pmu_s1_reg <= pmu_evt_i;
            pmu_s2_reg <= pmu_s1_reg;
            line_s1_reg <= line_state_i;
            line_s2_reg <= line_s1_reg;
            line_prev_reg <= line_s2_reg;
        end
    end

    // ***************************************************************
    // event status
    // ***************************************************************
    logic evt_rise;
    logic evt_rise_next;

    assign evt_rise = evt_s2_reg & ~evt_prev_reg;

    always_comb
    begin
        evt_rise_next = evt_rise_reg;
        if (sel(ctrl_regs_pkg::CPU_EVENT_STATUS_OFS) &
            we[ctrl_regs_pkg::EVT_RISE_BIT])
        begin
            evt_rise_next = wd[ctrl_regs_pkg::EVT_RISE_BIT];
        end
        // hardware set beats software clear
        if (evt_rise)
        begin
            evt_rise_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            evt_rise_reg <= 1'b0;
        end
        else
        begin
            evt_rise_reg <= evt_rise_next;
        end
    end

    // ***************************************************************
    // read mux and apb answer
    // ***************************************************************
    always_comb
    begin
        hit = 1'b1;
        rd_val = 16'h0000;
        case (paddr_i)
            ctrl_regs_pkg::CPU_CORE_CTRL_OFS: rd_val = core_ctrl_reg;
            ctrl_regs_pkg::CPU_FILTER_START_LOW_OFS: rd_val = start_low_reg;
            ctrl_regs_pkg::CPU_FILTER_END_LOW_OFS: rd_val = end_low_reg;
            ctrl_regs_pkg::CPU_FILTER_HIGH_AND_FIQ_OFS: rd_val = high_fiq_reg;
            ctrl_regs_pkg::CPU_MARGIN_AND_EVENTS_OFS: rd_val = margin_reg;
            ctrl_regs_pkg::CPU_EVENT_STATUS_OFS:
            begin
                rd_val[ctrl_regs_pkg::EVT_RISE_BIT] = evt_rise_reg;
                rd_val[ctrl_regs_pkg::PMU_LSB +: 12] = pmu_s2_reg;
            end
            ctrl_regs_pkg::OTG_PHY_POWER_CONTROL_OFS: rd_val = otg_pwr_reg;
            ctrl_regs_pkg::OTG_PHY_TRANSMIT_TRIM_OFS: rd_val = otg_trim_reg;
            default: hit = 1'b0;
        endcase
    end

    // ready in the first access cycle; no wait states
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= psel_i & ~penable_i;
            pslverr_reg <= psel_i & ~penable_i & ~hit;
            prdata_reg <= 32'h0000_0000;
            if (psel_i & ~penable_i & ~pwrite_i)
            begin
                prdata_reg <= {16'h0000, rd_val};
            end
        end
    end

    // ***************************************************************
    // line-state interrupt output
    // ***************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= otg_pwr_reg[ctrl_regs_pkg::LINE_PEND_BIT] &
                otg_pwr_reg[ctrl_regs_pkg::LINE_EN_BIT];
        end
    end

    // ***************************************************************
    // outputs, all slices of flops
    // ***************************************************************
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign prdata_o = prdata_reg;
    assign otg_line_irq_o = irq_reg;

    assign cpu_cfg_o.trace_port_ctl = core_ctrl_reg[9];
    assign cpu_cfg_o.debug_instance_id = core_ctrl_reg[8:5];
    assign cpu_cfg_o.l2_reset_hold_off = core_ctrl_reg[4];
    assign cpu_cfg_o.per_core_l1_reset_hold_off = core_ctrl_reg[3:0];
    assign cpu_cfg_o.filter_start = {high_fiq_reg[3:0], start_low_reg};
    assign cpu_cfg_o.filter_end = {high_fiq_reg[7:4], end_low_reg};
    assign cpu_cfg_o.core_nonmaskable_fast_irq_cfg =
        high_fiq_reg[11:8];
    assign cpu_cfg_o.l2_ram_margin = margin_reg[15:13];
    assign cpu_cfg_o.core_ram_margin = margin_reg[12:10];
    assign cpu_cfg_o.event_out_clear = margin_reg[9];
    assign cpu_cfg_o.event_in_drive = margin_reg[8];
    assign cpu_cfg_o.core_exception_state_init = margin_reg[3:0];

    assign otg_cfg_o.line_irq_enable = otg_pwr_reg[14];
    assign otg_cfg_o.analog_power_down = otg_pwr_reg[13];
    assign otg_cfg_o.port_reset = otg_pwr_reg[12];
    assign otg_cfg_o.scale_down_mode = otg_pwr_reg[9:8];
    assign otg_cfg_o.vbus_valid_trim = otg_pwr_reg[7:5];
    assign otg_cfg_o.block_power_down = otg_pwr_reg[4];
    assign otg_cfg_o.disconnect_trim = otg_pwr_reg[3:1];
    assign otg_cfg_o.common_down_in_suspend = otg_pwr_reg[0];
    assign otg_cfg_o.rise_fall_trim = otg_trim_reg[15:14];
    assign otg_cfg_o.crossover_trim = otg_trim_reg[13:12];
    assign otg_cfg_o.hs_dc_trim = otg_trim_reg[11:8];
    assign otg_cfg_o.fsls_impedance_trim = otg_trim_reg[7:4];

endmodule

// [test/ctrl_regs_props.sv]
// Purpose: port-level checks on the cpu/otg control bank
// Assumes: single clock, synchronous active-low reset
// Notes: helper registers keep the value before each write
module ctrl_regs_props
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    // cluster and phy
    input wire logic event_out_i,
    input wire ctrl_regs_pkg::pmu_evt_t pmu_evt_i,
    input wire ctrl_regs_pkg::cpu_cfg_t cpu_cfg_o,
    input wire logic [1:0] line_state_i,
    input wire ctrl_regs_pkg::otg_cfg_t otg_cfg_o,
    input wire logic otg_line_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] wd_reg;
    logic [15:0] start_reg;
    logic en_reg;

    // ****************************************
    // helpers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        wd_reg <= pwdata_i;
        start_reg <= cpu_cfg_o.filter_start[15:0];
        en_reg <= otg_cfg_o.line_irq_enable;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence wr_at(a);
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
    endsequence
    sequence rd_at(a);
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i == a;
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    AST_READY: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer after setup");
    AST_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    AST_IDLE_ZERO: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    AST_HALF_ZERO: assert property (pready_o |-> prdata_o[31:16] == 16'h0)
        else $error("mask half not zero");
    AST_ERR_DATA: assert property (pslverr_o |-> pready_o && !prdata_o)
        else $error("error without ready or with data");
    AST_MASK_MERGE: assert property (wr_at(12'h2FC) |=>
        cpu_cfg_o.filter_start[15:0] == ((start_reg & ~wd_reg[31:16])
        | (wd_reg[15:0] & wd_reg[31:16])))
        else $error("masked merge wrong");
    AST_START_HIGH: assert property (
        wr_at(12'h304) ##0 pwdata_i[19:16] == 4'hF
        |=> cpu_cfg_o.filter_start[19:16] == wd_reg[3:0])
        else $error("start high nibble wrong");
    AST_END_HIGH: assert property (
        wr_at(12'h304) ##0 pwdata_i[23:20] == 4'hF
        |=> cpu_cfg_o.filter_end[19:16] == wd_reg[7:4])
        else $error("end high nibble wrong");
    AST_RSVD_RD: assert property (rd_at(12'h304) |-> !prdata_o[15:12])
        else $error("reserved bits read nonzero");
    AST_CFG_HOLD: assert property (!(psel_i && penable_i && pwrite_i)
        |=> $stable(cpu_cfg_o) && $stable(otg_cfg_o))
        else $error("config moved without write");
    AST_IRQ_EN: assert property (otg_line_irq_o |-> en_reg)
        else $error("irq while disabled");
endmodule

bind cpu_otg_ctrl_regs ctrl_regs_props u_props (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .event_out_i(event_out_i), .pmu_evt_i(pmu_evt_i),
    .cpu_cfg_o(cpu_cfg_o), .line_state_i(line_state_i),
    .otg_cfg_o(otg_cfg_o), .otg_line_irq_o(otg_line_irq_o));

// [test/tb_top.sv]
// Purpose: self-checking bench for the cpu/otg control bank
// Assumes: apb master tasks, one idle cycle between transfers
// Notes: line and event inputs move only between transfers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, event_out_i;
    logic pready_o, pslverr_o, otg_line_irq_o, e;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [1:0] line_state_i;
    ctrl_regs_pkg::pmu_evt_t pmu_evt_i;
    ctrl_regs_pkg::cpu_cfg_t cpu_cfg_o;
    ctrl_regs_pkg::otg_cfg_t otg_cfg_o;
    int fails, compares;

    cpu_otg_ctrl_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .event_out_i(event_out_i), .pmu_evt_i(pmu_evt_i),
        .cpu_cfg_o(cpu_cfg_o), .line_state_i(line_state_i),
        .otg_cfg_o(otg_cfg_o), .otg_line_irq_o(otg_line_irq_o));

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do
        begin
            @(posedge clk_i);
        end
        while (pready_o !== 1'h1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(r, x);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [11:0] ra [8] = '{12'h2F8, 12'h2FC, 12'h300, 12'h304,
            12'h308, 12'h318, 12'h320, 12'h324};
        logic [31:0] rv [8] = '{32'h220, 32'hFF0, 32'hFFF, 32'h0,
            32'h2400, 32'h0, 32'h89, 32'h7330};
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i]);
        chk({27'h0, cpu_cfg_o.trace_port_ctl,
            cpu_cfg_o.debug_instance_id}, 32'h11);
        chk({12'h0, cpu_cfg_o.filter_end}, 32'hFFF);
        chk({25'h0, otg_cfg_o.vbus_valid_trim, otg_cfg_o.disconnect_trim,
            otg_cfg_o.common_down_in_suspend}, 32'h49);
    endtask

    task automatic t_cpu;
        wr(12'h2F8, 32'h03FF_0010);
        rd(12'h2F8, 32'h10);
        wr(12'h2F8, 32'h000F_000A);
        rd(12'h2F8, 32'h1A);
        chk({27'h0, cpu_cfg_o.l2_reset_hold_off,
            cpu_cfg_o.per_core_l1_reset_hold_off}, 32'h1A);
        wr(12'h2FC, 32'h00FF_ABCD);
        rd(12'h2FC, 32'hFCD);
        wr(12'h304, 32'hFFFF_FFFF);
        rd(12'h304, 32'hFFF);
        chk({12'h0, cpu_cfg_o.filter_start}, 32'hF0FCD);
        chk({12'h0, cpu_cfg_o.filter_end}, 32'hF0FFF);
        chk({28'h0, cpu_cfg_o.core_nonmaskable_fast_irq_cfg}, 32'hF);
        wr(12'h304, 32'h0);
        rd(12'h304, 32'hFFF);
        wr(12'h308, 32'hFFFF_FFFF);
        rd(12'h308, 32'hFF0F);
        chk({20'h0, cpu_cfg_o.l2_ram_margin, cpu_cfg_o.core_ram_margin,
            cpu_cfg_o.event_out_clear, cpu_cfg_o.event_in_drive,
            cpu_cfg_o.core_exception_state_init}, 32'hFFF);
    endtask

    task automatic t_otg;
        wr(12'h320, 32'h7FFF_7FFF);
        rd(12'h320, 32'h73FF);
        chk({20'h0, otg_cfg_o.analog_power_down, otg_cfg_o.port_reset,
            otg_cfg_o.scale_down_mode, otg_cfg_o.vbus_valid_trim,
            otg_cfg_o.block_power_down, otg_cfg_o.disconnect_trim,
            otg_cfg_o.common_down_in_suspend}, 32'hFFF);
        wr(12'h320, 32'h3000_0000);
        rd(12'h320, 32'h43FF);
        chk({30'h0, otg_cfg_o.analog_power_down,
            otg_cfg_o.port_reset}, 32'h0);
        wr(12'h324, 32'hFFFF_0000);
        rd(12'h324, 32'h0);
        chk({20'h0, otg_cfg_o.rise_fall_trim, otg_cfg_o.crossover_trim,
            otg_cfg_o.hs_dc_trim, otg_cfg_o.fsls_impedance_trim},
            32'h0);
    endtask

    task automatic t_status;
        pmu_evt_i <= 12'hA5C;
        event_out_i <= 1'h1;
        repeat (8) @(posedge clk_i);
        rd(12'h318, 32'h6970);
        wr(12'h318, 32'h4000_0000);
        rd(12'h318, 32'h2970);
    endtask

    task automatic t_line;
        line_state_i <= 2'h1;
        repeat (8) @(posedge clk_i);
        chk({31'h0, otg_line_irq_o}, 32'h1);
        rd(12'h320, 32'hC3FF);
        chk({31'h0, otg_cfg_o.line_irq_enable}, 32'h1);
        wr(12'h320, 32'h8000_0000);
        repeat (3) @(posedge clk_i);
        chk({31'h0, otg_line_irq_o}, 32'h0);
    endtask

    task automatic t_unmapped;
        wr(12'h310, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        rd(12'h310, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic final_report;
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // main
    // ****************************************
    initial
    begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    initial
    begin
        rst_n_i = 1'h0;
        psel_i = 1'h0;
        penable_i = 1'h0;
        pwrite_i = 1'h0;
        paddr_i = 12'h0;
        pwdata_i = 32'h0;
        event_out_i = 1'h0;
        pmu_evt_i = 12'h0;
        line_state_i = 2'h0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'h1;
        t_reset;
        t_cpu;
        t_otg;
        t_status;
        t_line;
        t_unmapped;
        final_report;
    end

    // whole run needs about 120 cycles
    initial
    begin
        repeat (3000) @(posedge clk_i);
        $display("mismatch t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
        fails++;
        final_report;
    end
endmodule
